// File: include/mon_alarm_pkg.sv
// Shared constants and types for the monitor alarm and alert logic.
package mon_alarm_pkg;
	localparam int NCH = 4;
	localparam int RES_W = 12;
	// Bus address of this slave; the value is arbitrary.
	localparam logic [6:0] OWN_ADDR = 7'h2a;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_THR = 8'h10;
	localparam logic [7:0] OFS_LATCH = 8'h20;
	localparam logic [7:0] OFS_CUR = 8'h30;
	localparam int CTRL_INT_EN = 0;
	localparam int CTRL_BIP = 1;
	localparam int CTRL_LAST_LO = 2;
	localparam int CTRL_DELAY_LO = 5;
	localparam logic [7:0] CTRL_RST = 8'h0c;
	localparam int SETUP_CLR_HI = 7;
	localparam logic [11:0] THR_LO_RST = 12'h000;
	localparam logic [11:0] THR_UP_RST = 12'hfff;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [RES_W-1:0] data;
	} conv_type;

	typedef struct packed {
		logic [RES_W-1:0] upper;
		logic [RES_W-1:0] lower;
	} thr_type;

	typedef struct packed {
		logic up;
		logic low;
		logic [RES_W-1:0] latched;
		logic [RES_W-1:0] current;
	} chan_stat_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_WR = 3'b011,
		ST_WACK = 3'b100,
		ST_RD = 3'b101,
		ST_RACK = 3'b110
	} i2c_state_type;
endpackage

// File: core/sync2.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module sync2
	import mon_alarm_pkg::*;
#(
	parameter int W = 2
)
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			meta_q <= '1;
			sync_q <= '1;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// File: core/alarm_chan.sv
// One channel: window compare, alarm bits, fault snapshot and latest result.
`timescale 1ns/100ps
module alarm_chan
	import mon_alarm_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic conv_in,
	input wire logic [RES_W-1:0] data_in,
	input wire thr_type thr_in,
	input wire logic bipolar_in,
	input wire logic clear_in,
	output chan_stat_type stat_out
);
	chan_stat_type st_q;
	chan_stat_type st_d;
	logic over;
	logic under;

	always_comb
	begin
		if (bipolar_in)
		begin
			over = $signed(data_in) > $signed(thr_in.upper);
			under = $signed(data_in) < $signed(thr_in.lower);
		end
		else
		begin
			over = data_in > thr_in.upper;
			under = data_in < thr_in.lower;
		end
		st_d = st_q;
		if (clear_in)
		begin
			st_d.up = 1'b0;
			st_d.low = 1'b0;
		end
		if (conv_in)
		begin
			st_d.current = data_in;
			if (over)
				st_d.up = 1'b1;
			if (under)
				st_d.low = 1'b1;
			// Snapshot when a fault first asserts.
			if ((over || under) && !(st_q.up || st_q.low) || (over || under) && clear_in)
				st_d.latched = data_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign stat_out = st_q;
endmodule

// File: core/mon_alarm.sv
// Alarm reporting, monitor read stream and alert response of the monitor.
//
// Functional notes
// - A fault on a channel with no alarm set captures the tripping result into its snapshot slot.
// - Alarm bit 1 means fault; snapshot then holds the tripping result.
// - Clearing alarms leaves snapshots untouched.
// - Current buffer holds each scanned channel's latest result taken outside suspension and monitor reads.
// - Reading past the last current word wraps to the first current word.
// - Snapshot block then current block, one 16-bit word per conversion.
// - With an interrupt pending, answer alert response with own address.
// - Open-drain arbitration decides; lower address wins.
// - Loser does not acknowledge and keeps the interrupt asserted.
// - Interrupt is released after own address was sent successfully.
// - Monitoring stays suspended after alert response until alarms are cleared.
// - On resume, alarms still set reassert the interrupt.
// - Results are straight binary unipolar, two's complement bipolar.
// - Writing 1 to a clear bit clears that channel; 0 does nothing.
// - Interrupt pin floats when disabled or no alarm pending.
// - Monitor read: status byte, snapshot words, then current words.
`timescale 1ns/100ps
module mon_alarm
	import mon_alarm_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire conv_type conv_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic int_out,
	output logic int_oe_out
);
	// ****************************************
	// Pin sampling
	// ****************************************
	logic [1:0] pins;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	sync2 #(.W(2)) pin_sync
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({scl_in, sda_in}),
		.sync_out(pins)
	);

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= pins[1];
			sda_p_q <= pins[0];
		end
	end

	assign scl_rise = pins[1] && !scl_p_q;
	assign scl_fall = !pins[1] && scl_p_q;
	assign bus_start = pins[1] && scl_p_q && sda_p_q && !pins[0];
	assign bus_stop = pins[1] && scl_p_q && !sda_p_q && pins[0];

	// ****************************************
	// Channels
	// ****************************************
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic susp_q;
	logic susp_d;
	logic masked_q;
	logic masked_d;
	thr_type [NCH-1:0] thr_q;
	thr_type [NCH-1:0] thr_d;
	chan_stat_type [NCH-1:0] cst;
	logic [NCH-1:0] clr;
	logic [NCH-1:0][RES_W-1:0] lat_w;
	logic [NCH-1:0][RES_W-1:0] cur_w;
	logic [7:0] alarm_byte;
	logic reading;
	logic conv_ok;
	logic int_line;

	// No conversions taken while suspended or during a monitor read.
	assign conv_ok = conv_in.valid && !susp_q && !reading;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			alarm_chan chan
			(
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.conv_in(conv_ok && conv_in.chan == 2'(g)),
				.data_in(conv_in.data),
				.thr_in(thr_q[g]),
				.bipolar_in(ctrl_q[CTRL_BIP]),
				.clear_in(clr[g]),
				.stat_out(cst[g])
			);
			assign alarm_byte[7-2*g] = cst[g].up;
			assign alarm_byte[6-2*g] = cst[g].low;
			assign lat_w[g] = cst[g].latched;
			assign cur_w[g] = cst[g].current;
		end
	endgenerate

	// Pin driven low only while enabled, alarmed and not released.
	assign int_line = ctrl_q[CTRL_INT_EN] && (|alarm_byte) && !masked_q;
	assign int_out = 1'b0;
	assign int_oe_out = int_line;

	// ****************************************
	// Read stream
	// ****************************************
	function automatic logic [7:0] stream_byte(input logic [4:0] ptr, input logic [2:0] n,
		input logic [7:0] stat, input logic [NCH-1:0][RES_W-1:0] lat,
		input logic [NCH-1:0][RES_W-1:0] cur);
		logic [4:0] idx;
		logic [4:0] k;
		logic [15:0] w;
		idx = ptr - 5'd1;
		k = idx - {1'b0, n, 1'b0};
		// Snapshot words first, then current words, zero-padded to 16 bits.
		if (idx < {1'b0, n, 1'b0})
			w = {4'h0, lat[idx[2:1]]};
		else
			w = {4'h0, cur[k[2:1]]};
		if (ptr == 5'd0)
			stream_byte = stat;
		else if (idx[0])
			stream_byte = w[7:0];
		else
			stream_byte = w[15:8];
	endfunction

	// ****************************************
	// Serial slave
	// ****************************************
	i2c_state_type st_q;
	i2c_state_type st_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic [4:0] ptr_q;
	logic [4:0] ptr_d;
	logic rw_q;
	logic rw_d;
	logic ara_q;
	logic ara_d;
	logic first_q;
	logic first_d;
	logic oe_q;
	logic oe_d;
	logic setup_we;
	logic alert_won;
	logic [2:0] nconv;
	logic [4:0] ptr_nx;

	assign nconv = {1'b0, ctrl_q[CTRL_LAST_LO+1:CTRL_LAST_LO]} + 3'd1;
	assign ptr_nx = (ptr_q == {nconv, 2'b00}) ? {1'b0, nconv, 1'b1} : ptr_q + 5'd1;
	assign reading = (st_q == ST_RD || st_q == ST_RACK) && !ara_q;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		ara_d = ara_q;
		first_d = first_q;
		oe_d = oe_q;
		setup_we = 1'b0;
		alert_won = 1'b0;
		if (bus_stop)
		begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end
		else if (bus_start)
		begin
			st_d = ST_ADDR;
			cnt_d = 4'd0;
			oe_d = 1'b0;
		end
		else
		begin
			case (st_q)
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], pins[0]};
						cnt_d = cnt_q + 4'd1;
					end
					else if (scl_fall && cnt_q == BYTE_BITS)
					begin
						rw_d = sh_q[0];
						ara_d = 1'b0;
						ptr_d = 5'd0;
						first_d = 1'b1;
						cnt_d = 4'd0;
						st_d = ST_AACK;
						oe_d = 1'b1;
						// Answer alert response only with an interrupt pending.
						if (sh_q[7:1] == ARA_ADDR && sh_q[0] && int_line)
							ara_d = 1'b1;
						else if (sh_q[7:1] != OWN_ADDR)
						begin
							st_d = ST_IDLE;
							oe_d = 1'b0;
						end
					end
				end
				ST_AACK:
				begin
					if (scl_fall)
					begin
						cnt_d = 4'd0;
						oe_d = 1'b0;
						st_d = ST_WR;
						if (rw_q)
						begin
							st_d = ST_RD;
							// Status byte leads a monitor read.
							tx_d = ara_q ? {OWN_ADDR, 1'b0}
								: stream_byte(5'd0, nconv, alarm_byte, lat_w, cur_w);
							oe_d = ara_q ? !OWN_ADDR[6] : !alarm_byte[7];
						end
					end
				end
				ST_WR:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], pins[0]};
						cnt_d = cnt_q + 4'd1;
					end
					else if (scl_fall && cnt_q == BYTE_BITS)
					begin
						// First written byte is the setup byte.
						setup_we = first_q;
						first_d = 1'b0;
						oe_d = 1'b1;
						st_d = ST_WACK;
					end
				end
				ST_WACK:
				begin
					if (scl_fall)
					begin
						oe_d = 1'b0;
						cnt_d = 4'd0;
						st_d = ST_WR;
					end
				end
				ST_RD:
				begin
					if (scl_rise)
					begin
						cnt_d = cnt_q + 4'd1;
						// Released a one but saw zero: lost, go quiet.
						if (!oe_q && tx_q[7] && !pins[0])
							st_d = ST_IDLE;
					end
					else if (scl_fall)
					begin
						if (cnt_q == BYTE_BITS)
						begin
							oe_d = 1'b0;
							st_d = ST_RACK;
							alert_won = ara_q;
						end
						else
						begin
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = !tx_q[6];
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
					begin
						if (pins[0] || ara_q)
							st_d = ST_IDLE;
						else
							ptr_d = ptr_nx;
					end
					else if (scl_fall)
					begin
						tx_d = stream_byte(ptr_q, nconv, alarm_byte, lat_w, cur_w);
						oe_d = !tx_d[7];
						cnt_d = 4'd0;
						st_d = ST_RD;
					end
				end
				default:
				begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 4'd0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 5'd0;
			rw_q <= 1'b0;
			ara_q <= 1'b0;
			first_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			ara_q <= ara_d;
			first_q <= first_d;
			oe_q <= oe_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = oe_q;

	// ****************************************
	// Register bus and control
	// ****************************************
	logic wr_q;
	logic [7:0] wa_q;
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic ap;
	logic [7:0] ra;
	logic ahb_clr;

	assign ap = hsel_in && hready_in && htrans_in[1];
	assign ra = haddr_in[7:0];
	assign ahb_clr = wr_q && wa_q == OFS_STATUS;

	// Ones clear the named channels; set in the same cycle still wins.
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			clr[i] = setup_we && sh_q[SETUP_CLR_HI-i] || ahb_clr && hwdata_in[i];
	end

	always_comb
	begin
		ctrl_d = ctrl_q;
		thr_d = thr_q;
		susp_d = susp_q;
		masked_d = masked_q;
		rd_d = 32'h0000_0000;
		if (wr_q && wa_q == OFS_CTRL)
			ctrl_d = hwdata_in[7:0];
		if (setup_we)
			ctrl_d = {sh_q[3:1], ctrl_q[CTRL_DELAY_LO-1:CTRL_BIP], sh_q[0]};
		for (int i = 0; i < NCH; i++)
			if (wr_q && wa_q == OFS_THR + 8'(4 * i))
				thr_d[i] = {hwdata_in[27:16], hwdata_in[11:0]};
		// Clearing an alarm resumes monitoring and re-arms the pin.
		if (|clr)
		begin
			susp_d = 1'b0;
			masked_d = 1'b0;
		end
		// Alert won: release pin and suspend.
		if (alert_won)
		begin
			susp_d = 1'b1;
			masked_d = 1'b1;
		end
		if (ra == OFS_CTRL)
			rd_d = {24'h000000, ctrl_q};
		else if (ra == OFS_STATUS)
			rd_d = {22'h0, int_line, susp_q, alarm_byte};
		for (int i = 0; i < NCH; i++)
		begin
			if (ra == OFS_THR + 8'(4 * i))
				rd_d = {4'h0, thr_q[i].upper, 4'h0, thr_q[i].lower};
			if (ra == OFS_LATCH + 8'(4 * i))
				rd_d = {20'h00000, lat_w[i]};
			if (ra == OFS_CUR + 8'(4 * i))
				rd_d = {20'h00000, cur_w[i]};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_q <= CTRL_RST;
			thr_q <= {NCH{THR_UP_RST, THR_LO_RST}};
			susp_q <= 1'b0;
			masked_q <= 1'b0;
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			thr_q <= thr_d;
			susp_q <= susp_d;
			masked_q <= masked_d;
			wr_q <= ap && hwrite_in;
			wa_q <= ra;
			rd_q <= (ap && !hwrite_in) ? rd_d : rd_q;
		end
	end

	assign hrdata_out = rd_q;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
endmodule

// File: sim/mon_alarm_asserts.sv
// Port-level assertions for the monitor alarm block.
`timescale 1ns/100ps
module mon_alarm_asserts
	import mon_alarm_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic int_out,
	input wire logic int_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic take;
	logic rd_any;
	logic wr_ctrl_q;
	logic wr_ctrl_d;
	logic rd_stat_q;
	logic rd_stat_d;
	assign take = hsel_in && hready_in && htrans_in[1];
	assign rd_any = take && !hwrite_in;
	always_comb
	begin
		wr_ctrl_d = take && hwrite_in && haddr_in[7:0] == OFS_CTRL;
		rd_stat_d = take && !hwrite_in && haddr_in[7:0] == OFS_STATUS;
	end
	always_ff @(posedge clk_in)
	begin
		wr_ctrl_q <= wr_ctrl_d && !sys_rst_in;
		rd_stat_q <= rd_stat_d && !sys_rst_in;
	end
	ready_high_a: assert property (hreadyout_out) else $error("hready low");
	resp_okay_a: assert property (!hresp_out) else $error("error response");
	sda_od_a: assert property (!sda_out) else $error("sda driven high");
	int_od_a: assert property (!int_out) else $error("int driven high");
	rst_idle_a: assert property ($fell(sys_rst_in) |-> !int_oe_out && !sda_oe_out)
		else $error("pins driven after reset");
	int_dis_a: assert property (wr_ctrl_q && !hwdata_in[CTRL_INT_EN] |=> !int_oe_out)
		else $error("int driven while disabled");
	stat_int_a: assert property (rd_stat_q |-> hrdata_out[9] == $past(int_oe_out))
		else $error("pending flag differs from pin");
	rdata_hold_a: assert property (!$past(rd_any) |-> $stable(hrdata_out))
		else $error("read data moved");
	cover property ($rose(sda_oe_out));
	cover property ($fell(int_oe_out));
	cover property (rd_stat_q && hrdata_out[8]);
endmodule
bind mon_alarm mon_alarm_asserts mon_alarm_asserts_i
(
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.hsel_in(hsel_in),
	.haddr_in(haddr_in),
	.htrans_in(htrans_in),
	.hwrite_in(hwrite_in),
	.hwdata_in(hwdata_in),
	.hready_in(hready_in),
	.hrdata_out(hrdata_out),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.int_out(int_out),
	.int_oe_out(int_oe_out)
);

// File: sim/smbus_host.sv
// Behavioural serial host with an optional rival responder on the data line.
`timescale 1ns/100ps
module smbus_host
(
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_out
);
	logic host_oe;
	logic rival_oe;
	initial
	begin
		scl_out = 1'b1;
		host_oe = 1'b0;
		rival_oe = 1'b0;
	end
	// The line has a pull-up, so any party that drives pulls it low.
	assign sda_out = !(sda_oe_in || host_oe || rival_oe);
	task automatic bit_io(input logic o, input logic r, output logic i);
	begin
		scl_out = 1'b0;
		#5 host_oe = !o;
		rival_oe = !r;
		#35 scl_out = 1'b1;
		#39 i = sda_out;
		#1;
	end
	endtask
	task automatic start();
	begin
		#1 host_oe = 1'b0;
		#40 host_oe = 1'b1;
		#40;
	end
	endtask
	task automatic stop();
	begin
		scl_out = 1'b0;
		#5 host_oe = 1'b1;
		rival_oe = 1'b0;
		#35 scl_out = 1'b1;
		#40 host_oe = 1'b0;
		#40;
	end
	endtask
	task automatic xfer(input logic [7:0] o, input logic [7:0] rv, input logic a_o,
		output logic [7:0] i, output logic a_i);
	begin
		for (int k = 7; k >= 0; k--)
			bit_io(o[k], rv[k], i[k]);
		bit_io(a_o, 1'b1, a_i);
	end
	endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench: register traffic, conversions and serial host.
`timescale 1ns/100ps
module testbench import mon_alarm_pkg::*;;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel_in = 1'b0;
	logic [31:0] haddr_in = '0;
	logic [1:0] htrans_in = '0;
	logic hwrite_in = 1'b0;
	logic [31:0] hwdata_in = '0;
	logic [31:0] hrdata_out;
	logic hreadyout_out;
	logic hresp_out;
	conv_type conv_in = '0;
	logic scl;
	logic sda;
	logic sda_oe_out;
	logic int_oe_out;
	logic rd_ph = 1'b0;
	logic [15:0] seed = 16'd56140;
	logic [31:0] exp_q[$];
	logic [31:0] got_q[$];
	int n_fail = 0;
	int checks = 0;
	mon_alarm mon_alarm_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .conv_in(conv_in),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe_out), .int_out(),
		.int_oe_out(int_oe_out));
	smbus_host smbus_host_i (.sda_oe_in(sda_oe_out), .scl_out(scl), .sda_out(sda));
	initial
	begin
		forever #5 clk_in = !clk_in;
	end
	function automatic logic [11:0] rnd();
	begin
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed[11:0];
	end
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
	begin
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task automatic end_of_test();
	begin
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task automatic wr();
		int k;
	begin
		k = 0;
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (!hreadyout_out && k < 20);
		if (!hreadyout_out)
		begin
			n_fail++;
			end_of_test();
		end
	end
	endtask
	// A read passes its expected data in d.
	task automatic ahb(input int w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		haddr_in <= {24'h0, a};
		hwrite_in <= w[0];
		wr();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= w[0] ? d : 32'h0;
		rd_ph <= !w[0];
		if (!w)
			exp_q.push_back(d);
		wr();
		rd_ph <= 1'b0;
	end
	endtask
	task automatic cv(input logic [1:0] c, input logic [11:0] d);
	begin
		@(posedge clk_in);
		conv_in <= '{1'b1, c, d};
		@(posedge clk_in);
		conv_in <= '0;
		repeat (3) @(posedge clk_in);
	end
	endtask
	// Sent bytes are judged by their ack bit, received bytes by their value.
	task automatic sb(input logic [7:0] o, input logic [7:0] rv, input logic a,
		input logic [7:0] e);
		logic [7:0] b;
		logic k;
	begin
		smbus_host_i.xfer(o, rv, a, b, k);
		exp_q.push_back({24'h0, e});
		got_q.push_back({24'h0, o == 8'hff ? b : {7'h0, k}});
	end
	endtask
	task automatic pin(input int e);
	begin
		repeat (4) @(posedge clk_in);
		exp_q.push_back({31'h0, e[0]});
		got_q.push_back({31'h0, int_oe_out});
	end
	endtask
	always @(posedge clk_in)
	begin
		while (got_q.size() > 0)
			chk(got_q.pop_front(), exp_q.pop_front());
		if (rd_ph && hreadyout_out)
			chk(hrdata_out, exp_q.pop_front());
	end
	initial
	begin
		#400000;
		n_fail++;
		end_of_test();
	end
	initial
	begin
		logic [11:0] t;
		logic [11:0] u;
		logic [11:0] x;
		logic [11:0] wv[9];
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		ahb(0, OFS_CTRL, 32'h0c);
		ahb(0, OFS_THR, 32'h0fff0000);
		ahb(0, 8'h80, 32'h0);
		for (int c = 0; c < NCH; c++)
			ahb(1, OFS_THR + 8'(4 * c), 32'h08000100);
		ahb(1, OFS_CTRL, 32'h0d);
		t = rnd();
		t = 12'h801 + (t & 12'h3ff);
		u = rnd();
		u = 12'h100 + (u & 12'h3ff);
		wv = '{12'h900, 12'h050, 12'h0ff, t, 12'h300, 12'h200, 12'h400, u, 12'h300};
		for (int n = 0; n < 8; n++)
			cv(2'(n % 4), wv[n]);
		ahb(0, OFS_STATUS, 32'h296);
		pin(1);
		smbus_host_i.start();
		sb(8'h55, 8'hff, 1'b1, 8'h0);
		sb(8'hff, 8'hff, 1'b0, 8'h96);
		for (int n = 0; n < 9; n++)
		begin
			x = wv[n];
			sb(8'hff, 8'hff, 1'b0, {4'h0, x[11:8]});
			sb(8'hff, 8'hff, n == 8, x[7:0]);
		end
		smbus_host_i.stop();
		smbus_host_i.start();
		sb({ARA_ADDR, 1'b1}, 8'hff, 1'b1, 8'h0);
		sb(8'hff, 8'h20, 1'b1, 8'h20);
		smbus_host_i.stop();
		pin(1);
		ahb(0, OFS_STATUS, 32'h296);
		smbus_host_i.start();
		sb({ARA_ADDR, 1'b1}, 8'hff, 1'b1, 8'h0);
		sb(8'hff, 8'hff, 1'b1, {OWN_ADDR, 1'b0});
		smbus_host_i.stop();
		pin(0);
		ahb(0, OFS_STATUS, 32'h196);
		cv(2'd1, 12'h600);
		ahb(0, OFS_CUR + 8'h4, 32'h200);
		smbus_host_i.start();
		sb({OWN_ADDR, 1'b0}, 8'hff, 1'b1, 8'h0);
		sb(8'h81, 8'hff, 1'b1, 8'h0);
		smbus_host_i.stop();
		ahb(0, OFS_STATUS, 32'h216);
		pin(1);
		ahb(0, OFS_CTRL, 32'h0d);
		ahb(0, OFS_LATCH, 32'h900);
		ahb(1, OFS_STATUS, 32'h0e);
		ahb(0, OFS_STATUS, 32'h0);
		pin(0);
		ahb(1, OFS_CTRL, 32'h0f);
		cv(2'd0, 12'ha00);
		ahb(0, OFS_STATUS, 32'h2c0);
		ahb(0, OFS_LATCH, 32'ha00);
		ahb(1, OFS_CTRL, 32'h0e);
		pin(0);
		repeat (5) @(posedge clk_in);
		end_of_test();
	end
endmodule
